/* File: src/svic_map.svh */
// Register offsets, field positions and reset values of the interrupt controller.
// Assumes an 8-bit special-register bus driven by the core.
`ifndef SVIC_MAP_SVH
`define SVIC_MAP_SVH
`define SVIC_OFS_EN_MAIN 9'h00b
`define SVIC_OFS_PEND_MAIN 9'h00c
`define SVIC_OFS_EN_PWM 9'h00d
`define SVIC_OFS_PEND_PWM 9'h00e
`define SVIC_OFS_CFG 9'h081
`define SVIC_RST_MAIN 8'h00
`define SVIC_RST_PWM 4'h0
`define SVIC_RST_CFG 8'h0f
`define SVIC_BIT_EDGE_A 6
`define SVIC_BIT_EDGE_B 5
`define SVIC_VECTOR 11'h004
`endif

/* File: src/svic_pkg.sv */
// Types shared by the interrupt controller.
// Assumes nothing beyond the map header.
package svic_pkg;
  typedef enum logic [1:0] {
    SVIC_IDLE = 2'b00,
    SVIC_SERVICE = 2'b01,
    SVIC_RETURNED = 2'b11
  } svic_state_t;
endpackage

/* File: src/svic_ctrl.sv */
// Single-level, single-vector interrupt controller with twelve sources.
// Assumes the core gives an instruction-end strobe and a return strobe, same clock.
`timescale 1ns/1ps
`include "svic_map.svh"

module svic_ctrl #(
  parameter int NUM_MAIN = 8,
  parameter int NUM_PWM = 4
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [8:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic [4:0] main_event,
  input wire logic [3:0] pwm_event,
  input wire logic ext_pin_a,
  input wire logic ext_pin_b,
  input wire logic ext_pin_c,
  input wire logic instr_end,
  input wire logic return_from_irq,
  output logic irq_call,
  output logic [10:0] irq_vector,
  output logic in_service,
  output logic irq_pending,
  output logic wake_idle,
  output logic wake_stop
);

  // Register map is fixed; refuse other source counts at elaboration
  if (NUM_MAIN != 8 || NUM_PWM != 4) begin : g_bad_count
    $error("svic_ctrl serves exactly eight main and four pwm sources");
  end

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  // Pins sampled on clk; stop-mode wake uses the raw pin levels instead.
  logic [2:0] pin_s1_q, pin_s1_d;
  logic [2:0] pin_s2_q, pin_s2_d;
  logic [2:0] pin_s3_q, pin_s3_d;
  logic [7:0] en_main_q, en_main_d;
  logic [7:0] pend_main_q, pend_main_d;
  logic [3:0] en_pwm_q, en_pwm_d;
  logic [3:0] pend_pwm_q, pend_pwm_d;
  logic [7:0] cfg_q, cfg_d;
  logic [7:0] set_main;
  logic [2:0] rise, fall;
  logic [2:0] pin_arm_q, pin_arm_d;

  always_comb begin
    pin_s1_d = {ext_pin_c, ext_pin_b, ext_pin_a};
    pin_s2_d = pin_s1_q;
    pin_s3_d = pin_s2_q;
    rise = pin_s2_q & ~pin_s3_q;
    fall = ~pin_s2_q & pin_s3_q;
    pin_arm_d = 3'h7;
  end

  // ----------------------------------------------------------------
  // Pending flags and enables
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [8:0] a, input logic [8:0] ofs);
    hit = (a == ofs);
  endfunction

  always_comb begin
    // Conversion, timebase, timer b, timer a and wake timer events
    // event mapping
    set_main[7:3] = main_event;
    set_main[2] = fall[2] & pin_arm_q[2];
    set_main[1] = (cfg_q[`SVIC_BIT_EDGE_B] ? rise[1] : fall[1]) & pin_arm_q[1];
    set_main[0] = (cfg_q[`SVIC_BIT_EDGE_A] ? rise[0] : fall[0]) & pin_arm_q[0];
    en_main_d = en_main_q;
    en_pwm_d = en_pwm_q;
    cfg_d = cfg_q;
    pend_main_d = pend_main_q;
    pend_pwm_d = pend_pwm_q;
    if (reg_wr && hit(reg_addr, `SVIC_OFS_EN_MAIN)) begin
      en_main_d = reg_wdata;
    end
    if (reg_wr && hit(reg_addr, `SVIC_OFS_EN_PWM)) begin
      en_pwm_d = reg_wdata[3:0];
    end
    if (reg_wr && hit(reg_addr, `SVIC_OFS_CFG)) begin
      cfg_d = reg_wdata;
    end
    if (reg_wr && hit(reg_addr, `SVIC_OFS_PEND_MAIN)) begin
      pend_main_d = pend_main_q & reg_wdata;
    end
    if (reg_wr && hit(reg_addr, `SVIC_OFS_PEND_PWM)) begin
      pend_pwm_d = pend_pwm_q & reg_wdata[3:0];
    end
    // set ignores enable, wins over clear
    pend_main_d = pend_main_d | set_main;
    pend_pwm_d = pend_pwm_d | pwm_event;
  end

  always_comb begin
    unique case (reg_addr)
      `SVIC_OFS_EN_MAIN: reg_rdata = en_main_q;
      `SVIC_OFS_PEND_MAIN: reg_rdata = pend_main_q;
      `SVIC_OFS_EN_PWM: reg_rdata = {4'h0, en_pwm_q};
      `SVIC_OFS_PEND_PWM: reg_rdata = {4'h0, pend_pwm_q};
      `SVIC_OFS_CFG: reg_rdata = cfg_q;
      default: reg_rdata = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Acceptance and in-service sequencing
  // ----------------------------------------------------------------
  svic_pkg::svic_state_t st_q, st_d;
  logic call_q, call_d;
  logic req;

  always_comb begin
    req = |(pend_main_q & en_main_q) | |(pend_pwm_q & en_pwm_q);
    st_d = st_q;
    call_d = 1'b0;
    unique case (st_q)
      svic_pkg::SVIC_IDLE: begin
        if (req && instr_end) begin
          st_d = svic_pkg::SVIC_SERVICE;
          call_d = 1'b1;
        end
      end
      svic_pkg::SVIC_SERVICE: begin
        if (return_from_irq && instr_end) begin
          st_d = svic_pkg::SVIC_RETURNED;
        end
      end
      svic_pkg::SVIC_RETURNED: begin
        if (instr_end) begin
          st_d = svic_pkg::SVIC_IDLE;
        end
      end
      default: st_d = svic_pkg::SVIC_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pin_s1_q <= 3'h7;
      pin_s2_q <= 3'h7;
      pin_s3_q <= 3'h7;
      pin_arm_q <= 3'h0;
      en_main_q <= `SVIC_RST_MAIN;
      pend_main_q <= `SVIC_RST_MAIN;
      en_pwm_q <= `SVIC_RST_PWM;
      pend_pwm_q <= `SVIC_RST_PWM;
      cfg_q <= `SVIC_RST_CFG;
      st_q <= svic_pkg::SVIC_IDLE;
      call_q <= 1'b0;
    end else begin
      pin_s1_q <= pin_s1_d;
      pin_s2_q <= pin_s2_d;
      pin_s3_q <= pin_s3_d;
      pin_arm_q <= pin_arm_d;
      en_main_q <= en_main_d;
      pend_main_q <= pend_main_d;
      en_pwm_q <= en_pwm_d;
      pend_pwm_q <= pend_pwm_d;
      cfg_q <= cfg_d;
      st_q <= st_d;
      call_q <= call_d;
    end
  end

  always_comb begin
    irq_call = call_q;
    irq_vector = `SVIC_VECTOR;
    in_service = (st_q != svic_pkg::SVIC_IDLE);
    irq_pending = req;
    // any enabled request wakes from idle
    wake_idle = req;
    // clockless pin wake for stop mode
    wake_stop = (en_main_q[2] & ~ext_pin_c)
      | (en_main_q[1] & (cfg_q[`SVIC_BIT_EDGE_B] ~^ ext_pin_b))
      | (en_main_q[0] & (cfg_q[`SVIC_BIT_EDGE_A] ~^ ext_pin_a));
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_accept;
    (st_q == svic_pkg::SVIC_IDLE) && req && instr_end;
  endsequence

  AST_ACCEPT_CALL: assert property (@(posedge clk) disable iff (srst) s_accept |=> irq_call && in_service)
    else $error("call not injected on acceptance");
  AST_NO_MID_INSTR: assert property (@(posedge clk) disable iff (srst)
    $rose(in_service) |-> $past(instr_end) && $past(req))
    else $error("accepted outside instruction end");
  AST_NO_NEST: assert property (@(posedge clk) disable iff (srst) in_service |=> !irq_call)
    else $error("nested call");
  AST_GAP_AFTER_RET: assert property (@(posedge clk) disable iff (srst)
    (st_q == svic_pkg::SVIC_SERVICE) && return_from_irq && instr_end |=> in_service)
    else $error("in-service cleared too early");
  AST_LEVEL_REQ: assert property (@(posedge clk) disable iff (srst)
    (pend_main_q[4] && en_main_q[4]) |-> irq_pending)
    else $error("enabled flag not requesting");
  AST_MASKED_SET: assert property (@(posedge clk) disable iff (srst) main_event[4] |=> pend_main_q[7])
    else $error("conversion flag not set");
  AST_SET_WINS: assert property (@(posedge clk) disable iff (srst)
    pwm_event[0] && reg_wr && reg_addr == `SVIC_OFS_PEND_PWM |=> pend_pwm_q[0])
    else $error("set lost against clear");
  AST_CLEAR: assert property (@(posedge clk) disable iff (srst)
    reg_wr && reg_addr == `SVIC_OFS_PEND_MAIN && !reg_wdata[3] && !main_event[0] |=> !pend_main_q[3])
    else $error("write of 0 did not clear");
  AST_PWM_EN: assert property (@(posedge clk) disable iff (srst) reg_addr == `SVIC_OFS_EN_PWM |-> reg_rdata[7:4] == 4'h0)
    else $error("unimplemented bits read nonzero");
  AST_PIN_C: assert property (@(posedge clk) disable iff (srst) fall[2] && pin_arm_q[2] |=> pend_main_q[2])
    else $error("pin c edge missed");

  // Call vector, return and re-entry steps
  sequence s_return;
    (st_q == svic_pkg::SVIC_SERVICE) && return_from_irq && instr_end;
  endsequence

  sequence s_reentry;
    (st_q == svic_pkg::SVIC_RETURNED) && instr_end;
  endsequence

  AST_VECTOR: assert property (@(posedge clk) disable iff (srst)
    irq_call |-> irq_vector == `SVIC_VECTOR)
    else $error("call vector wrong");
  AST_RET_STEP: assert property (@(posedge clk) disable iff (srst)
    s_return |=> st_q == svic_pkg::SVIC_RETURNED)
    else $error("return not recorded");
  AST_REENTRY: assert property (@(posedge clk) disable iff (srst)
    s_reentry |=> !in_service)
    else $error("in-service not released after return");

  // Flag capture per source
  AST_EN_FREE: assert property (@(posedge clk) disable iff (srst)
    main_event[4] && !en_main_q[7] |=> pend_main_q[7])
    else $error("disabled source lost its flag");
  AST_TIMEBASE: assert property (@(posedge clk) disable iff (srst)
    main_event[3] |=> pend_main_q[6])
    else $error("timebase flag not set");
  AST_TIMER_B: assert property (@(posedge clk) disable iff (srst)
    main_event[2] |=> pend_main_q[5])
    else $error("timer b flag not set");
  AST_TIMER_A: assert property (@(posedge clk) disable iff (srst)
    main_event[1] |=> pend_main_q[4])
    else $error("timer a flag not set");
  AST_WAKE_TMR: assert property (@(posedge clk) disable iff (srst)
    main_event[0] |=> pend_main_q[3])
    else $error("wake timer flag not set");
  AST_PIN_B: assert property (@(posedge clk) disable iff (srst)
    rise[1] && cfg_q[`SVIC_BIT_EDGE_B] && pin_arm_q[1] |=> pend_main_q[1])
    else $error("pin b rising edge missed");
  AST_PIN_A: assert property (@(posedge clk) disable iff (srst)
    fall[0] && !cfg_q[`SVIC_BIT_EDGE_A] && pin_arm_q[0] |=> pend_main_q[0])
    else $error("pin a falling edge missed");
  AST_PERIOD: assert property (@(posedge clk) disable iff (srst)
    pwm_event[3] |=> pend_pwm_q[3])
    else $error("period flag not set");
  AST_DUTY: assert property (@(posedge clk) disable iff (srst)
    pwm_event[2:0] != 3'h0 |=> (pend_pwm_q[2:0] & $past(pwm_event[2:0])) == $past(pwm_event[2:0]))
    else $error("duty flag not set");

  // Request and wake
  AST_NO_FLAG_NO_REQ: assert property (@(posedge clk) disable iff (srst)
    pend_main_q == 8'h00 && pend_pwm_q == 4'h0 |-> !irq_pending)
    else $error("request without flag");
  AST_WAKE_IDLE: assert property (@(posedge clk) disable iff (srst)
    pend_pwm_q[3] && en_pwm_q[3] |-> wake_idle)
    else $error("enabled request did not wake");
  AST_STOP_PIN: assert property (@(posedge clk) disable iff (srst)
    en_main_q[2] && !ext_pin_c |-> wake_stop)
    else $error("pin c level did not wake from stop");

endmodule // svic_ctrl

/* File: verif/svic_core_model.sv */
// Core model: instruction-end strobes and the return-from-interrupt strobe.
// Assumes the controller's clock and reset; one instruction lasts four cycles.
`timescale 1ns/1ps
module svic_core_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic ret_req,
  output logic instr_end,
  output logic return_from_irq
);
  logic [1:0] cnt_q;
  always_ff @(posedge clk) begin
    cnt_q <= srst ? 2'h0 : cnt_q + 2'h1;
  end
  assign instr_end = !srst && (cnt_q == 2'h3);
  assign return_from_irq = instr_end && ret_req;
endmodule // svic_core_model

/* File: verif/svic_ctrl_tb.sv */
// Self-checking bench for the interrupt controller.
// Assumes the core model supplies instruction ends; reads are checked from a queue.
`timescale 1ns/1ps
`include "svic_map.svh"
module svic_ctrl_tb;
  localparam logic [8:0] em = `SVIC_OFS_EN_MAIN;
  localparam logic [8:0] pm = `SVIC_OFS_PEND_MAIN;
  localparam logic [8:0] ep = `SVIC_OFS_EN_PWM;
  localparam logic [8:0] pp = `SVIC_OFS_PEND_PWM;
  localparam logic [8:0] cf = `SVIC_OFS_CFG;
  logic clk = 0, srst = 1, reg_wr = 0, ret_req = 0, obs_v = 0, obs_s = 0, ie_q = 0;
  logic pa = 1, pb = 1, pc = 1, instr_end, return_from_irq, irq_call, in_service, irq_pending, wake_idle;
  logic wake_stop;
  logic [8:0] reg_addr = 9'h0;
  logic [7:0] reg_wdata = 8'h0, reg_rdata, got;
  logic [4:0] main_event = 5'h0;
  logic [3:0] pwm_event = 4'h0;
  logic [10:0] irq_vector;
  logic [7:0] q[$];
  logic [31:0] lfsr = 32'h002b;
  int n_mismatch = 0, comparisons = 0, n_call = 0;
  always #2.5 clk = ~clk;
  svic_core_model core_u (.clk(clk), .srst(srst), .ret_req(ret_req), .instr_end(instr_end),
    .return_from_irq(return_from_irq));
  svic_ctrl dut_u (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .main_event(main_event), .pwm_event(pwm_event), .ext_pin_a(pa), .ext_pin_b(pb),
    .ext_pin_c(pc), .instr_end(instr_end), .return_from_irq(return_from_irq), .irq_call(irq_call),
    .irq_vector(irq_vector), .in_service(in_service), .irq_pending(irq_pending), .wake_idle(wake_idle),
    .wake_stop(wake_stop));
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic cmp(input string nm, input logic [10:0] e, input logic [10:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ----------------------------------------
  // Output watcher
  // ----------------------------------------
  always @(posedge clk) begin
    if (irq_call === 1'b1) begin
      n_call++;
      cmp("vector", 11'h004, irq_vector);
      cmp("accept", 11'h1, {10'h0, ie_q});
    end
    if (obs_v === 1'b1) begin
      got = obs_s ? {4'h0, wake_stop, wake_idle, irq_pending, in_service} : reg_rdata;
      cmp(obs_s ? "status" : "rdata", {3'h0, q.pop_front()}, {3'h0, got});
    end
    ie_q <= instr_end;
  end
  task automatic op(input logic [8:0] a, input logic [7:0] d, input logic w, input logic [4:0] m,
    input logic [3:0] p);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    main_event <= m;
    pwm_event <= p;
    @(posedge clk);
    reg_wr <= 1'b0;
    main_event <= 5'h0;
    pwm_event <= 4'h0;
  endtask
  task automatic chk(input logic s, input logic [8:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    obs_s <= s;
    obs_v <= 1'b1;
    q.push_back(e);
    @(posedge clk);
    obs_v <= 1'b0;
  endtask
  // Exactly one instruction end falls in four held cycles
  task automatic ret;
    @(posedge clk);
    ret_req <= 1'b1;
    repeat (4) @(posedge clk);
    ret_req <= 1'b0;
  endtask
  task automatic wait_for(input int n);
    for (int i = 0; i < 200 && n_call < n; i++) @(posedge clk);
    if (n_call < n) begin
      n_mismatch++;
      report_and_stop;
    end
  endtask
  initial begin
    logic [8:0] ad[5];
    logic [4:0] m;
    logic [3:0] p;
    ad = '{em, pm, ep, pp, cf};
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 5; i++) chk(0, ad[i], (i == 4) ? 8'h0f : 8'h00);
    op(9'h000, 8'hff, 1, 0, 0);
    chk(0, 9'h000, 8'h00);
    op(em, 8'ha5, 1, 0, 0);
    op(ep, 8'hff, 1, 0, 0);
    chk(0, em, 8'ha5);
    chk(0, ep, 8'h0f);
    op(em, 8'h00, 1, 0, 0);
    op(ep, 8'h00, 1, 0, 0);
    for (int i = 0; i < 6; i++) begin
      lfsr = nxt(lfsr);
      m = lfsr[4:0];
      p = lfsr[8:5];
      op(9'h000, 8'h00, 0, m, p);
      chk(0, pp, {4'h0, p});
      chk(1, 9'h000, 8'h00);
      op(pm, {lfsr[16:12], 3'h7}, 1, 0, 0);
      chk(0, pm, {m & lfsr[16:12], 3'h0});
      op(pm, 8'h00, 1, 0, 4'h0);
      op(pp, 8'h00, 1, 0, 0);
    end
    op(pm, 8'h00, 1, 5'h10, 4'h0);
    chk(0, pm, 8'h80);
    for (int s = 0; s < 2; s++) for (int l = 0; l < 2; l++) begin
      op(cf, {1'b0, s[0], s[0], 5'h1f}, 1, 0, 0);
      {pa, pb, pc} <= {3{l[0]}};
      repeat (5) @(posedge clk);
      op(pm, 8'h00, 1, 0, 0);
      {pa, pb, pc} <= {3{!l[0]}};
      repeat (5) @(posedge clk);
      chk(0, pm, {5'h0, l[0], {2{l[0] != s[0]}}});
    end
    op(pm, 8'h00, 1, 0, 0);
    op(em, 8'h07, 1, 0, 0);
    chk(1, 9'h000, 8'h08);
    op(em, 8'h00, 1, 0, 0);
    op(ep, 8'h01, 1, 0, 0);
    op(9'h000, 8'h00, 0, 0, 4'h1);
    wait_for(1);
    chk(1, 9'h000, 8'h07);
    repeat (12) @(posedge clk);
    chk(1, 9'h000, 8'h07);
    cmp("calls", 11'h1, n_call[10:0]);
    ret();
    wait_for(2);
    op(pp, 8'h00, 1, 0, 0);
    ret();
    repeat (8) @(posedge clk);
    chk(1, 9'h000, 8'h00);
    cmp("calls", 11'h2, n_call[10:0]);
    report_and_stop;
  end
endmodule // svic_ctrl_tb
